/* File: core/scu_cfg.svh */
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH
// system clock period, then bus clock periods per speed grade, in ns
`define SCU_CLK_NS 4
`define SCU_SM_PERIOD_NS 10000
`define SCU_FM_PERIOD_NS 2500
`define SCU_FMP_PERIOD_NS 1000
// half period, a least time: rounded up to whole cycles
`define SCU_SM_HALF ((`SCU_SM_PERIOD_NS / 2 + `SCU_CLK_NS - 1) / `SCU_CLK_NS)
`define SCU_FM_HALF ((`SCU_FM_PERIOD_NS / 2 + `SCU_CLK_NS - 1) / `SCU_CLK_NS)
`define SCU_FMP_HALF ((`SCU_FMP_PERIOD_NS / 2 + `SCU_CLK_NS - 1) / `SCU_CLK_NS)
`define SCU_TMR_W 12
`define SCU_SPD_SM 2'h0
`define SCU_SPD_FM 2'h1
`define SCU_SPD_FMP 2'h2
`define SCU_BYTE_BITS 4'h8
`define SCU_LAST_BIT 4'h7
`define SCU_STOP_END 4'h3
`define SCU_EV_W 4
`define SCU_EV_RXLVL 0
`define SCU_EV_MDONE 1
`define SCU_EV_ARB 2
`define SCU_EV_STOP 3
`endif

/* File: core/scu_dual_i2c.sv */
// Function
// - two independent serial units are built, each working as an i2c port.
// - each unit acts as master or slave and drops out when it loses arbitration.
// - transfers run at up to 1 Mbps in the fast-plus speed grade.
// - standard, fast and fast-plus timing and framing are followed on the bus.
// - a receive level threshold decides when software is notified.
// - in mailbox mode bus writes fill a local byte array and bus reads are served from it.
// - each unit has an eight-entry receive and an eight-entry transmit fifo.
// - the bus clock is held low while no buffer room or data is available.
// - both lines are only pulled low or released, never driven high.
// - during reset both lines are released and nothing loads the bus.
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"
module scu_dual_i2c import scu_pkg::*; #(
   parameter int NCH = 2,
   parameter int FIFO_DEPTH = 8,
   parameter int MB_AW = 5
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [NCH-1:0] scl_link_clk,
   input wire logic [NCH-1:0] scl_in,
   output logic [NCH-1:0] scl_out,
   output logic [NCH-1:0] scl_oe,
   input wire logic [NCH-1:0] sda_in,
   output logic [NCH-1:0] sda_out,
   output logic [NCH-1:0] sda_oe,
   input wire logic [NCH-1:0] unit_en,
   input wire logic [NCH-1:0][1:0] speed_sel,
   input wire logic [NCH-1:0][6:0] own_addr,
   input wire logic [NCH-1:0] memory_mailbox_mode,
   input wire logic [NCH-1:0] ext_clock_addr_match_en,
   input wire logic [NCH-1:0] ext_clock_operation_en,
   input wire logic [NCH-1:0] cmd_valid,
   output logic [NCH-1:0] cmd_ready,
   input wire logic [NCH-1:0][7:0] cmd_addr,
   input wire logic [NCH-1:0][3:0] cmd_len,
   input wire logic [NCH-1:0] tx_valid,
   output logic [NCH-1:0] tx_ready,
   input wire logic [NCH-1:0][7:0] tx_data,
   output logic [NCH-1:0] rx_valid,
   input wire logic [NCH-1:0] rx_ready,
   output logic [NCH-1:0][7:0] rx_data,
   input wire logic [NCH-1:0][3:0] rx_thresh,
   input wire logic [NCH-1:0] mb_cpu_we,
   input wire logic [NCH-1:0][MB_AW-1:0] mb_cpu_addr,
   input wire logic [NCH-1:0][7:0] mb_cpu_wdata,
   output logic [NCH-1:0][7:0] mb_cpu_rdata,
   input wire logic [NCH-1:0][`SCU_EV_W-1:0] ev_clear,
   input wire logic [NCH-1:0][`SCU_EV_W-1:0] ev_mask,
   output logic [NCH-1:0][`SCU_EV_W-1:0] ev_status,
   output logic [NCH-1:0] irq
);
   if (NCH < 1 || FIFO_DEPTH < 2 || MB_AW < 1 || MB_AW > 8) begin : g_chk
      $error("unsupported channel count, fifo depth or mailbox size");
   end
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   function automatic logic [`SCU_TMR_W-1:0] half_cnt(input logic [1:0] spd);
      case (spd)
         `SCU_SPD_FM: half_cnt = `SCU_TMR_W'(`SCU_FM_HALF);
         `SCU_SPD_FMP: half_cnt = `SCU_TMR_W'(`SCU_FMP_HALF);
         default: half_cnt = `SCU_TMR_W'(`SCU_SM_HALF);
      endcase
   endfunction

   // pull-low request for the master's next bit slot
   function automatic logic bit_drive(input logic tx, input logic [3:0] n,
                                      input logic [7:0] d, input logic more);
      if (n < `SCU_BYTE_BITS) bit_drive = tx & ~d[7];
      else bit_drive = ~tx & more;
   endfunction

   for (genvar gi = 0; gi < NCH; gi++) begin : g_unit
      logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
      logic lnk_bit_r, lnk_tgl_r, lt_m, lt_s, lt_p;
      logic start_det, stop_det, scl_fall, lnk_evt, addr_ph, use_lnk, rx_evt, rx_bit;
      scu_state_t st_r;
      logic [7:0] sh_r;
      logic [3:0] bcnt_r, left_r;
      logic [`SCU_TMR_W-1:0] tmr_r;
      logic scl_drv_r, sda_drv_r, pend_r, rw_r, nack_r, m_tx_r, m_rd_r, busy_r;
      logic [MB_AW-1:0] mb_ptr_r;
      logic mb_first_r;
      logic [7:0] mb_mem [2**MB_AW];
      logic [`SCU_EV_W-1:0] ev_r, ev_set;
      logic mbx, m_act, s_store_go, s_load_go, m_load_go, m_push_go, s_avail;
      logic [7:0] s_byte;
      logic rxf_ready, txf_valid;
      logic [7:0] txf_data;
      logic [LW-1:0] rx_lvl;

      // pin inputs through two flops before use, apart from the sda bit caught on the link clock below
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
            {lt_m, lt_s, lt_p} <= 3'h0;
         end else if (clk_en) begin
            scl_m <= scl_in[gi];
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_in[gi];
            sda_s <= sda_m;
            sda_p <= sda_s;
            lt_m <= lnk_tgl_r;
            lt_s <= lt_m;
            lt_p <= lt_s;
         end
      end

      // bit capture on the bus clock itself; the bit holds until the next
      // rising edge, far longer than the toggle takes to cross
      always_ff @(posedge scl_link_clk[gi] or posedge sys_rst) begin
         if (sys_rst) begin
            lnk_bit_r <= 1'b0;
            lnk_tgl_r <= 1'b0;
         end else begin
            lnk_bit_r <= sda_in[gi];
            lnk_tgl_r <= ~lnk_tgl_r;
         end
      end

      assign start_det = scl_s & scl_p & sda_p & ~sda_s;
      assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
      assign scl_fall = scl_p & ~scl_s;
      assign lnk_evt = lt_s ^ lt_p;
      assign addr_ph = (st_r == SCU_S_ADDR);
      assign use_lnk = addr_ph ? ext_clock_addr_match_en[gi] : ext_clock_operation_en[gi];
      assign rx_evt = use_lnk ? lnk_evt : (scl_s & ~scl_p);
      assign rx_bit = use_lnk ? lnk_bit_r : sda_s;
      assign mbx = memory_mailbox_mode[gi];
      assign m_act = (st_r == SCU_M_START) | (st_r == SCU_M_LOW) |
                     (st_r == SCU_M_HIGH) | (st_r == SCU_M_STOP);
      assign s_byte = mbx ? mb_mem[mb_ptr_r] : txf_data;
      assign s_avail = mbx | txf_valid;

      always_comb begin
         s_store_go = (st_r == SCU_S_WR) && (scl_fall || pend_r) &&
                      (bcnt_r == `SCU_BYTE_BITS) && (mbx || rxf_ready);
         s_load_go = (st_r == SCU_S_RACK) && (scl_fall || pend_r) && !nack_r && s_avail;
         m_load_go = (st_r == SCU_M_LOW) && pend_r && m_tx_r && txf_valid;
         m_push_go = (st_r == SCU_M_LOW) && pend_r && !m_tx_r && rxf_ready;
      end

      assign cmd_ready[gi] = unit_en[gi] & (st_r == SCU_IDLE) & ~busy_r & ~start_det;

      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            busy_r <= 1'b0;
         end else if (clk_en) begin
            if (start_det) busy_r <= 1'b1;
            else if (stop_det) busy_r <= 1'b0;
         end
      end

      // one engine serves both roles; lines only ever pulled low
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            st_r <= SCU_IDLE;
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b0;
            sh_r <= 8'h00;
            bcnt_r <= 4'h0;
            left_r <= 4'h0;
            tmr_r <= '0;
            pend_r <= 1'b0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            m_tx_r <= 1'b0;
            m_rd_r <= 1'b0;
         end else if (clk_en) begin
            if (!unit_en[gi]) begin
               st_r <= SCU_IDLE;
               scl_drv_r <= 1'b0;
               sda_drv_r <= 1'b0;
               pend_r <= 1'b0;
            end else if (!m_act && start_det) begin
               st_r <= SCU_S_ADDR;
               bcnt_r <= 4'h0;
               sda_drv_r <= 1'b0;
               scl_drv_r <= 1'b0;
               pend_r <= 1'b0;
            end else if (!m_act && stop_det) begin
               st_r <= SCU_IDLE;
               sda_drv_r <= 1'b0;
               scl_drv_r <= 1'b0;
               pend_r <= 1'b0;
            end else begin
               case (st_r)
                  SCU_IDLE: begin
                     if (cmd_valid[gi] && cmd_ready[gi]) begin
                        sh_r <= cmd_addr[gi];
                        m_rd_r <= cmd_addr[gi][0];
                        left_r <= cmd_len[gi];
                        m_tx_r <= 1'b1;
                        sda_drv_r <= 1'b1;
                        tmr_r <= half_cnt(speed_sel[gi]);
                        st_r <= SCU_M_START;
                     end
                  end
                  SCU_S_ADDR, SCU_S_WR: begin
                     if (rx_evt && bcnt_r < `SCU_BYTE_BITS) begin
                        sh_r <= {sh_r[6:0], rx_bit};
                        bcnt_r <= bcnt_r + 4'h1;
                     end else if (addr_ph && scl_fall && bcnt_r == `SCU_BYTE_BITS) begin
                        // full seven-bit compare; an odd address under mixed
                        // sampling clocks may miss
                        if (sh_r[7:1] == own_addr[gi]) begin
                           sda_drv_r <= 1'b1;
                           rw_r <= sh_r[0];
                           st_r <= SCU_S_ACK;
                        end else begin
                           st_r <= SCU_IDLE;
                        end
                     end else if (!addr_ph && (scl_fall || pend_r) &&
                                  bcnt_r == `SCU_BYTE_BITS) begin
                        if (s_store_go) begin
                           scl_drv_r <= 1'b0;
                           pend_r <= 1'b0;
                           sda_drv_r <= 1'b1;
                           st_r <= SCU_S_ACK;
                        end else begin
                           scl_drv_r <= 1'b1;
                           pend_r <= 1'b1;
                        end
                     end
                  end
                  SCU_S_ACK: begin
                     if (scl_fall) begin
                        sda_drv_r <= 1'b0;
                        bcnt_r <= 4'h0;
                        nack_r <= 1'b0;
                        pend_r <= rw_r;
                        st_r <= rw_r ? SCU_S_RACK : SCU_S_WR;
                     end
                  end
                  SCU_S_RD: begin
                     if (scl_fall) begin
                        bcnt_r <= bcnt_r + 4'h1;
                        if (bcnt_r == `SCU_LAST_BIT) begin
                           sda_drv_r <= 1'b0;
                           st_r <= SCU_S_RACK;
                        end else begin
                           sh_r <= {sh_r[6:0], 1'b0};
                           sda_drv_r <= ~sh_r[6];
                        end
                     end
                  end
                  SCU_S_RACK: begin
                     if (rx_evt) nack_r <= rx_bit;
                     if (s_load_go) begin
                        sh_r <= s_byte;
                        sda_drv_r <= ~s_byte[7];
                        bcnt_r <= 4'h0;
                        scl_drv_r <= 1'b0;
                        pend_r <= 1'b0;
                        st_r <= SCU_S_RD;
                     end else if ((scl_fall || pend_r) && nack_r) begin
                        pend_r <= 1'b0;
                        st_r <= SCU_IDLE;
                     end else if (scl_fall || pend_r) begin
                        scl_drv_r <= 1'b1;
                        pend_r <= 1'b1;
                     end
                  end
                  SCU_M_START: begin
                     if (tmr_r == '0) begin
                        scl_drv_r <= 1'b1;
                        bcnt_r <= 4'h0;
                        sda_drv_r <= bit_drive(1'b1, 4'h0, sh_r, 1'b0);
                        tmr_r <= half_cnt(speed_sel[gi]);
                        st_r <= SCU_M_LOW;
                     end else begin
                        tmr_r <= tmr_r - 1'b1;
                     end
                  end
                  SCU_M_LOW: begin
                     if (m_load_go) begin
                        sh_r <= txf_data;
                        sda_drv_r <= ~txf_data[7];
                        pend_r <= 1'b0;
                     end else if (m_push_go) begin
                        sda_drv_r <= bit_drive(1'b0, `SCU_BYTE_BITS, sh_r, left_r != 4'h0);
                        pend_r <= 1'b0;
                     end else if (!pend_r && tmr_r == '0) begin
                        scl_drv_r <= 1'b0;
                        tmr_r <= half_cnt(speed_sel[gi]);
                        st_r <= SCU_M_HIGH;
                     end else if (!pend_r) begin
                        tmr_r <= tmr_r - 1'b1;
                     end
                  end
                  SCU_M_HIGH: begin
                     // a slave holding the clock low restarts the high phase
                     if (!scl_s) begin
                        tmr_r <= half_cnt(speed_sel[gi]);
                     end else if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                     end else if (!sda_drv_r && !sda_s && m_tx_r &&
                                  bcnt_r < `SCU_BYTE_BITS) begin
                        sda_drv_r <= 1'b0;
                        st_r <= SCU_IDLE;
                     end else begin
                        sh_r <= {sh_r[6:0], sda_s};
                        scl_drv_r <= 1'b1;
                        tmr_r <= half_cnt(speed_sel[gi]);
                        if (bcnt_r < `SCU_BYTE_BITS) begin
                           bcnt_r <= bcnt_r + 4'h1;
                           st_r <= SCU_M_LOW;
                           if (!m_tx_r && bcnt_r == `SCU_LAST_BIT) begin
                              pend_r <= 1'b1;
                              sda_drv_r <= 1'b0;
                           end else begin
                              sda_drv_r <= bit_drive(m_tx_r, bcnt_r + 4'h1,
                                                     {sh_r[6:0], sda_s}, left_r != 4'h0);
                           end
                        end else if (left_r == 4'h0 || (m_tx_r && sda_s)) begin
                           bcnt_r <= 4'h0;
                           sda_drv_r <= 1'b0;
                           st_r <= SCU_M_STOP;
                        end else begin
                           left_r <= left_r - 4'h1;
                           bcnt_r <= 4'h0;
                           m_tx_r <= ~m_rd_r;
                           pend_r <= ~m_rd_r;
                           sda_drv_r <= 1'b0;
                           st_r <= SCU_M_LOW;
                        end
                     end
                  end
                  SCU_M_STOP: begin
                     if (tmr_r != '0) begin
                        if (bcnt_r != 4'h2 || scl_s) tmr_r <= tmr_r - 1'b1;
                     end else begin
                        bcnt_r <= bcnt_r + 4'h1;
                        tmr_r <= half_cnt(speed_sel[gi]);
                        case (bcnt_r)
                           4'h0: sda_drv_r <= 1'b1;
                           4'h1: scl_drv_r <= 1'b0;
                           4'h2: sda_drv_r <= 1'b0;
                           default: st_r <= SCU_IDLE;
                        endcase
                     end
                  end
                  default: st_r <= SCU_IDLE;
               endcase
            end
         end
      end

      assign scl_out[gi] = 1'b0;
      assign sda_out[gi] = 1'b0;
      assign scl_oe[gi] = scl_drv_r;
      assign sda_oe[gi] = sda_drv_r;

      // mailbox: first written byte sets the pointer, later bytes go to the array
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            mb_ptr_r <= '0;
            mb_first_r <= 1'b0;
            mb_cpu_rdata[gi] <= 8'h00;
         end else if (clk_en) begin
            mb_cpu_rdata[gi] <= mb_mem[mb_cpu_addr[gi]];
            if (addr_ph && scl_fall && bcnt_r == `SCU_BYTE_BITS && !sh_r[0])
               mb_first_r <= 1'b1;
            if (mbx && s_store_go) begin
               mb_first_r <= 1'b0;
               mb_ptr_r <= mb_first_r ? sh_r[MB_AW-1:0] : mb_ptr_r + 1'b1;
            end else if (mbx && s_load_go) begin
               mb_ptr_r <= mb_ptr_r + 1'b1;
            end
         end
      end

      // a bus write wins the array port over a cpu write in the same cycle
      always_ff @(posedge sys_clk) begin
         if (clk_en) begin
            if (mbx && s_store_go && !mb_first_r) mb_mem[mb_ptr_r] <= sh_r;
            else if (mb_cpu_we[gi]) mb_mem[mb_cpu_addr[gi]] <= mb_cpu_wdata[gi];
         end
      end

      scu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx (
         .clk(sys_clk),
         .rst(sys_rst),
         .ce(clk_en),
         .in_valid((s_store_go && !mbx) || m_push_go),
         .in_ready(rxf_ready),
         .in_data(sh_r),
         .out_valid(rx_valid[gi]),
         .out_ready(rx_ready[gi]),
         .out_data(rx_data[gi]),
         .level(rx_lvl)
      );

      scu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx (
         .clk(sys_clk),
         .rst(sys_rst),
         .ce(clk_en),
         .in_valid(tx_valid[gi]),
         .in_ready(tx_ready[gi]),
         .in_data(tx_data[gi]),
         .out_valid(txf_valid),
         .out_ready((s_load_go && !mbx) || m_load_go),
         .out_data(txf_data),
         .level()
      );

      always_comb begin
         ev_set = '0;
         ev_set[`SCU_EV_RXLVL] = (rx_thresh[gi] != 4'h0) &&
                                 (rx_lvl >= LW'(rx_thresh[gi]));
         ev_set[`SCU_EV_MDONE] = (st_r == SCU_M_STOP) && (bcnt_r == `SCU_STOP_END) &&
                                 (tmr_r == '0);
         ev_set[`SCU_EV_ARB] = (st_r == SCU_M_HIGH) && scl_s && (tmr_r == '0) &&
                               !sda_drv_r && !sda_s && m_tx_r &&
                               (bcnt_r < `SCU_BYTE_BITS);
         ev_set[`SCU_EV_STOP] = stop_det && !m_act && (st_r != SCU_IDLE);
      end

      // a new event outlasts a clear in the same cycle
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) ev_r <= '0;
         else if (clk_en) ev_r <= (ev_r & ~ev_clear[gi]) | ev_set;
      end

      assign ev_status[gi] = ev_r;
      assign irq[gi] = |(ev_r & ev_mask[gi]);
   end
endmodule
`default_nettype wire

/* File: core/scu_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module scu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign level = cnt_r;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         if (push && !pop) cnt_r <= cnt_r + 1'b1;
         else if (pop && !push) cnt_r <= cnt_r - 1'b1;
      end
   end
   // storage has no reset: contents are only read once counted in
   always_ff @(posedge clk) begin
      if (ce && push) mem[wp_r] <= in_data;
   end
endmodule
`default_nettype wire

/* File: core/scu_pkg.sv */
package scu_pkg;
   typedef enum logic [9:0] {
      SCU_IDLE = 10'b00_0000_0001,
      SCU_S_ADDR = 10'b00_0000_0010,
      SCU_S_ACK = 10'b00_0000_0100,
      SCU_S_WR = 10'b00_0000_1000,
      SCU_S_RD = 10'b00_0001_0000,
      SCU_S_RACK = 10'b00_0010_0000,
      SCU_M_START = 10'b00_0100_0000,
      SCU_M_LOW = 10'b00_1000_0000,
      SCU_M_HIGH = 10'b01_0000_0000,
      SCU_M_STOP = 10'b10_0000_0000
   } scu_state_t;
endpackage

/* File: test/scu_dual_i2c_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scu_cfg.svh"
module scu_dual_i2c_checker #(
   parameter int NCH = 2
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [NCH-1:0] scl_out,
   input wire logic [NCH-1:0] scl_oe,
   input wire logic [NCH-1:0] sda_out,
   input wire logic [NCH-1:0] sda_oe,
   input wire logic [NCH-1:0] unit_en,
   input wire logic [NCH-1:0][1:0] speed_sel,
   input wire logic [NCH-1:0] cmd_valid,
   input wire logic [NCH-1:0] cmd_ready,
   input wire logic [NCH-1:0][`SCU_EV_W-1:0] ev_clear,
   input wire logic [NCH-1:0][`SCU_EV_W-1:0] ev_mask,
   input wire logic [NCH-1:0][`SCU_EV_W-1:0] ev_status,
   input wire logic [NCH-1:0] irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   open_drain_a: assert property (scl_out == '0 && sda_out == '0)
      else $error("line driven high");
   rst_release_a: assert property ($fell(sys_rst) |-> scl_oe == '0 && sda_oe == '0)
      else $error("line pulled out of reset");
   irq_sum_a: assert property (irq[0] == |(ev_status[0] & ev_mask[0]))
      else $error("irq differs from masked status");
   start_seq_a: assert property (cmd_valid[0] && cmd_ready[0] |=> sda_oe[0] && !scl_oe[0])
      else $error("no start after command");
   busy_hold_a: assert property (cmd_valid[0] && cmd_ready[0] |=> !cmd_ready[0] [*8])
      else $error("ready during transfer");
   fmp_half_a: assert property (cmd_valid[0] && cmd_ready[0] && speed_sel[0] == 2'h2
      |=> !scl_oe[0] [*8] ##[100:130] scl_oe[0]) else $error("fast-plus half period off");
   unit_off_a: assert property (!unit_en[0] |=> !scl_oe[0] && !sda_oe[0])
      else $error("disabled unit pulls a line");
   ev_clear_a: assert property (ev_clear[0][1] && cmd_ready[0] |=> !ev_status[0][1])
      else $error("event not cleared");
endmodule
bind scu_dual_i2c scu_dual_i2c_checker #(.NCH(NCH)) chk_u (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
   .sda_oe(sda_oe), .unit_en(unit_en), .speed_sel(speed_sel), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .ev_clear(ev_clear), .ev_mask(ev_mask), .ev_status(ev_status),
   .irq(irq));
`default_nettype wire

/* File: test/scu_i2c_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scu_i2c_bus_model (
   input wire logic [1:0] scl_oe,
   input wire logic [1:0] sda_oe,
   output wire logic scl,
   output wire logic sda
);
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   logic [7:0] got[$];
   // pull-ups: any party pulling low wins, released means high
   assign scl = ~|scl_oe;
   assign sda = ~|sda_oe;
   // the master moves data in the same step as the clock falls, so a start
   // only counts if the clock is still high a moment later
   always @(negedge sda) #1 if (scl) cnt <= 4'h0;
   // bytes are logged msb first; the ninth clock carries the ack and is skipped
   always @(posedge scl) begin
      if (cnt == 4'h8) begin
         got.push_back(sh);
         cnt <= 4'h0;
      end else begin
         sh <= {sh[6:0], sda};
         cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] scl_oe, sda_oe, cmd_ready, irq, rx_vld;
   logic [1:0] unit_en = '0, cmd_valid = '0, tx_valid = '0, mbx = 2'b10, rx_ready = '0, ext = 2'b10;
   logic [1:0][1:0] speed = {2'h2, 2'h2};
   logic [1:0][6:0] own = {7'h2a, 7'h11};
   logic [1:0][7:0] cmd_addr = '0, tx_data = '0, mb_rd, rx_dat;
   logic [1:0][3:0] cmd_len = '0, ev_clear = '0, ev_mask = '0, ev_status;
   logic [1:0][4:0] mb_addr = '0;
   wire logic scl, sda;
   int bad_count = 0, comparisons = 0, seed = 32'h377f, i;
   logic [7:0] ptr, val;
   always #2 sys_clk = ~sys_clk;
   scu_i2c_bus_model bus_u (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   scu_dual_i2c dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .scl_link_clk({scl, scl}), .scl_in({scl, scl}), .scl_out(), .scl_oe(scl_oe),
      .sda_in({sda, sda}), .sda_out(), .sda_oe(sda_oe), .unit_en(unit_en), .speed_sel(speed),
      .own_addr(own), .memory_mailbox_mode(mbx), .ext_clock_addr_match_en(ext),
      .ext_clock_operation_en(2'b00), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .tx_valid(tx_valid), .tx_ready(),
      .tx_data(tx_data), .rx_valid(rx_vld), .rx_ready(rx_ready), .rx_data(rx_dat),
      .rx_thresh({4'h0, 4'h1}),
      .mb_cpu_we(2'b00), .mb_cpu_addr(mb_addr), .mb_cpu_wdata('0), .mb_cpu_rdata(mb_rd),
      .ev_clear(ev_clear), .ev_mask(ev_mask), .ev_status(ev_status), .irq(irq));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         bad_count++;
         summarize();
      end
   endtask
   // ready is looked at mid-cycle, the request drops at the edge that takes it
   task automatic run_cmd(input logic [7:0] a, input logic [3:0] n);
      cmd_addr[0] <= a;
      cmd_len[0] <= n;
      cmd_valid <= 2'b01;
      @(negedge sys_clk);
      for (i = 0; i < 100 && cmd_ready[0] !== 1'b1; i++) @(negedge sys_clk);
      guard(i, 100);
      @(posedge sys_clk);
      cmd_valid <= 2'b00;
      for (i = 0; i < 20000 && ev_status[0][1] !== 1'b1; i++) @(posedge sys_clk);
      guard(i, 20000);
      @(posedge sys_clk);
      check({7'h00, irq[0]}, 8'h01);
      ev_clear[0] <= 4'h2;
      @(posedge sys_clk);
      ev_clear[0] <= 4'h0;
      @(posedge sys_clk);
      check({7'h00, irq[0]}, 8'h00);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      check({4'h0, scl_oe, sda_oe}, 8'h00);
      sys_rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      unit_en <= 2'b11;
      ev_mask[0] <= 4'h2;
      ptr = 8'($random(seed)) & 8'h1f;
      val = 8'($random(seed));
      // unit 0 writes pointer then value into unit 1's mailbox at fast-plus rate
      tx_data[0] <= ptr;
      tx_valid <= 2'b01;
      @(posedge sys_clk);
      tx_data[0] <= val;
      @(posedge sys_clk);
      tx_valid <= 2'b00;
      run_cmd(8'h54, 4'h2);
      check(bus_u.got[0], 8'h54);
      check(bus_u.got[1], ptr);
      check(bus_u.got[2], val);
      $display("test master_write done");
      mb_addr[1] <= ptr[4:0];
      repeat (3) @(posedge sys_clk);
      check(mb_rd[1], val);
      $display("test mailbox_read done");
      // pointer-only write, then one byte read back over the bus
      tx_data[0] <= ptr;
      tx_valid <= 2'b01;
      @(posedge sys_clk);
      tx_valid <= 2'b00;
      run_cmd(8'h54, 4'h1);
      run_cmd(8'h55, 4'h1);
      check(bus_u.got[5], 8'h55);
      check(bus_u.got[6], val);
      check(rx_dat[0], val);
      check({6'h00, rx_vld[0], ev_status[0][0]}, 8'h03);
      $display("test master_read done");
      summarize();
   end
endmodule
`default_nettype wire
